/* File: hw/idct_core.sv */
// instruction decode and cycle timing for an 8-bit core
// assumes instruction words arrive on IWORD with IVALID, held until ITAKE pulses,
// and SKIP_TRUE reports the skip test of the instruction being issued
//
// Overview of operation
// - each 13-bit instruction splits into an opcode and operand fields
// - by default one instruction cycle, lasting two oscillator periods
// - writing the program counter register takes two instruction cycles
// - option bit 10: zero gives two periods per cycle, one gives four
// - long branch option: jumps, returns, true skips take two cycles, else one
// - cycle length and long branch options act independently
// - four periods selected: timer clock enable is oscillator divided by four
// - any bit of any register can be set, cleared or tested
// - port registers are addressed as ordinary registers
// - register field, bit field, and 8 or 10 bit literal are extracted
// - halt and watchdog clear ops clear watchdog; halt stops; both touch T,P
// - pop op loads the program counter from the stack top only
// - irq on/off ops set/clear global enable; pop with irq on also sets it
// - control write/read ops copy between accumulator and control register
// - mode word store/load copy accumulator to and from mode register
// - bcd fix-up op adjusts accumulator and updates only carry
// - zero accumulator and zero register ops update the zero flag
// - subtract computes register minus accumulator, updates Z, C and DC
// - count down computes register minus one, updates only Z
// - accumulator to register copy changes no flag
`timescale 1ns/1ps
module idct_core import idct_pkg::*; #(
	parameter int IW = IDCT_IW
) (
	input  wire logic          REF_CLK,
	input  wire logic          RST,
	input  wire logic [IW-1:0] OPTION_WORD,
	input  wire logic          LONG_BRANCH_SEL,
	input  wire logic [IW-1:0] IWORD,
	input  wire logic          IVALID,
	input  wire logic          SKIP_TRUE,
	output idct_dec_type       DEC,
	output logic               DEC_VALID,
	output logic               ITAKE,
	output logic               CYCLE_TICK,
	output logic               TIMER_TICK,
	output logic [1:0]         CYCLES_USED
);

	// ------------------------------------------------------------
	// option capture
	// ------------------------------------------------------------
	// options are fixed words; registered every reference clock, so a change acts one clock later
	logic cycle_length_sel_q;
	logic long_branch_sel_q;

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			cycle_length_sel_q <= 1'b0;
			long_branch_sel_q  <= 1'b0;
		end else begin
			cycle_length_sel_q <= OPTION_WORD[IDCT_OPT_CLK];
			long_branch_sel_q  <= LONG_BRANCH_SEL;
		end
	end

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	function automatic idct_dec_type decode(input logic [IW-1:0] w);
		idct_dec_type d;
		d = '0;
		d.reg_sel = w[5:0];
		d.bit_sel = w[8:6];
		d.literal = w[9:0];
		d.sub     = w[7:6];
		if (w[12]) begin
			d.lit_wide = ~w[11];
			if (!w[11]) begin
				d.unit   = w[10] ? IDCT_U_JUMP : IDCT_U_CALL;
				d.branch = 1'b1;
			end else begin
				d.unit    = IDCT_U_LIT;
				d.literal = {2'b00, w[7:0]};
				d.upd_z   = (w[10:8] != 3'b000);
			end
		end else if (w[11]) begin
			// bit ops reach any register, ports included, by the same field
			unique case (w[10:9])
				2'b00: d.unit = IDCT_U_BCLR;
				2'b01: d.unit = IDCT_U_BSET;
				2'b10: begin
					d.unit      = IDCT_U_BTSTC;
					d.cond_skip = 1'b1;
				end
				2'b11: begin
					d.unit      = IDCT_U_BTSTS;
					d.cond_skip = 1'b1;
				end
			endcase
			d.to_reg = ~w[10];
		end else if (w[10:6] == 5'h00) begin
			d.unit = IDCT_U_SYS;
			if (w[5:4] == 2'b00) begin
				d.bcd_fix  = (w == IDCT_BCD);
				d.upd_c    = (w == IDCT_BCD);
				d.mode_st  = (w == IDCT_MWST);
				d.halt     = (w == IDCT_HALT);
				d.wdog_clr = (w == IDCT_HALT) || (w == IDCT_WDCL);
				d.upd_tp   = d.wdog_clr;
				d.ctrl_wr  = (w[3:0] > 4'h4);
			end else if (w[5:4] == 2'b01) begin
				d.irq_on  = (w == IDCT_IRQON) || (w == IDCT_POPI);
				d.irq_off = (w == IDCT_IRQOF);
				d.pop_pc  = (w == IDCT_POP) || (w == IDCT_POPI);
				d.branch  = d.pop_pc;
				d.mode_ld = (w == IDCT_MWLD);
				d.ctrl_rd = (w[3:0] > 4'h4);
			end else begin
				d.unit = IDCT_U_COPY;
				d.to_reg = 1'b1;
			end
		end else if (w[10:8] == 3'b000) begin
			unique case (w[7:6])
				2'b01: begin
					d.unit   = IDCT_U_COPY;
					d.to_reg = 1'b1;
				end
				2'b10: begin
					d.unit     = IDCT_U_CLR;
					d.zero_acc = (w == IDCT_ZACC);
					d.upd_z    = (w == IDCT_ZACC);
				end
				2'b11: begin
					d.unit   = IDCT_U_CLR;
					d.to_reg = 1'b1;
					d.upd_z  = 1'b1;
				end
				default: d.unit = IDCT_U_SYS;
			endcase
		end else begin
			d.to_reg = w[6];
			unique case (w[10:8])
				3'b001: begin
					d.unit   = w[7] ? IDCT_U_DEC : IDCT_U_SUB;
					d.upd_z  = 1'b1;
					d.upd_c  = ~w[7];
					d.upd_dc = ~w[7];
				end
				3'b010: begin
					d.unit  = IDCT_U_LOGIC;
					d.upd_z = 1'b1;
				end
				3'b011: begin
					d.unit   = (w[7:6] == 2'b11 || w[7:6] == 2'b10) ? IDCT_U_ADD : IDCT_U_LOGIC;
					d.upd_z  = 1'b1;
					d.upd_c  = w[7];
					d.upd_dc = w[7];
				end
				3'b100: begin
					d.unit  = w[7] ? IDCT_U_COM : IDCT_U_MOVE;
					d.upd_z = 1'b1;
				end
				3'b101: begin
					d.unit      = w[7] ? IDCT_U_DSKIP : IDCT_U_INC;
					d.upd_z     = ~w[7];
					d.cond_skip = w[7];
				end
				3'b110: begin
					d.unit  = IDCT_U_ROT;
					d.upd_c = 1'b1;
				end
				default: begin
					d.unit      = w[7] ? IDCT_U_ISKIP : IDCT_U_SWAP;
					d.cond_skip = w[7];
				end
			endcase
		end
		// any register-result op aimed at the pc register reloads the pc
		d.pc_write = d.to_reg && (d.reg_sel == 6'(IDCT_PC_REG)) &&
			(d.unit != IDCT_U_SYS) && (d.unit != IDCT_U_BTSTC) &&
			(d.unit != IDCT_U_BTSTS);
		return d;
	endfunction

	// ------------------------------------------------------------
	// cycle timing
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		IDCT_S_IDLE = 3'b001,
		IDCT_S_RUN  = 3'b010,
		IDCT_S_DONE = 3'b100
	} idct_state_type;

	idct_state_type state_q;
	logic [1:0]     osc_cnt_q;
	logic [1:0]     cyc_left_q;
	logic [1:0]     cyc_used_q;
	logic           cycle_end;
	logic [1:0]     per_last;
	idct_dec_type   dec_now;
	logic [1:0]     need;

	always_comb begin
		per_last = cycle_length_sel_q ? 2'(IDCT_PER_LONG - 1) : 2'(IDCT_PER_SHORT - 1);
		cycle_end = (osc_cnt_q >= per_last);
		dec_now  = decode(IWORD);
		need = 2'd1;
		if (dec_now.pc_write)
			need = 2'd2;
		else if (long_branch_sel_q && (dec_now.branch || (dec_now.cond_skip && SKIP_TRUE)))
			need = 2'd2;
	end

	// period counter; shared by every cycle so long cycles stretch too
	always_ff @(posedge REF_CLK) begin
		if (RST)
			osc_cnt_q <= 2'd0;
		else if (cycle_end)
			osc_cnt_q <= 2'd0;
		else
			osc_cnt_q <= osc_cnt_q + 2'd1;
	end

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			CYCLE_TICK <= 1'b0;
			TIMER_TICK <= 1'b0;
		end else begin
			CYCLE_TICK <= cycle_end;
			TIMER_TICK <= cycle_end;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			state_q    <= IDCT_S_IDLE;
			cyc_left_q <= 2'd0;
			cyc_used_q <= 2'd0;
			ITAKE      <= 1'b0;
			DEC_VALID  <= 1'b0;
			DEC        <= '0;
		end else begin
			ITAKE     <= 1'b0;
			DEC_VALID <= 1'b0;
			unique case (state_q)
				IDCT_S_IDLE: begin
					if (cycle_end && IVALID) begin
						DEC        <= dec_now;
						DEC_VALID  <= 1'b1;
						ITAKE      <= 1'b1;
						cyc_left_q <= need - 2'd1;
						cyc_used_q <= need;
						state_q    <= (need == 2'd1) ? IDCT_S_DONE : IDCT_S_RUN;
					end
				end
				IDCT_S_RUN: begin
					if (cycle_end) begin
						cyc_left_q <= cyc_left_q - 2'd1;
						if (cyc_left_q == 2'd1)
							state_q <= IDCT_S_DONE;
					end
				end
				IDCT_S_DONE: begin
					state_q <= IDCT_S_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RST)
			CYCLES_USED <= 2'd0;
		else
			CYCLES_USED <= cyc_used_q;
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	pc_two_cycle_a: assert property (@(posedge REF_CLK) disable iff (RST)
		(state_q == IDCT_S_IDLE && cycle_end && IVALID && dec_now.pc_write) |=> (cyc_used_q == 2'd2))
		else $error("pc write not two cycles");
	short_branch_a: assert property (@(posedge REF_CLK) disable iff (RST)
		(state_q == IDCT_S_IDLE && cycle_end && IVALID && !long_branch_sel_q && !dec_now.pc_write)
		|=> (cyc_used_q == 2'd1))
		else $error("branch took two cycles with option low");
	long_branch_a: assert property (@(posedge REF_CLK) disable iff (RST)
		(state_q == IDCT_S_IDLE && cycle_end && IVALID && long_branch_sel_q && dec_now.branch)
		|=> (cyc_used_q == 2'd2))
		else $error("branch took one cycle with option high");
	period_len_a: assert property (@(posedge REF_CLK) disable iff (RST)
		(cycle_end && cycle_length_sel_q && $stable(cycle_length_sel_q)) |=> !cycle_end [*3])
		else $error("long cycle shorter than four periods");
	short_period_a: assert property (@(posedge REF_CLK) disable iff (RST)
		(cycle_end && !cycle_length_sel_q && $stable(cycle_length_sel_q)) |=> !cycle_end ##1 cycle_end)
		else $error("short cycle not two periods");
	timer_rate_a: assert property (@(posedge REF_CLK) disable iff (RST)
		TIMER_TICK |-> $past(cycle_end))
		else $error("timer tick off cycle boundary");
	take_once_a: assert property (@(posedge REF_CLK) disable iff (RST)
		ITAKE |=> !ITAKE)
		else $error("word taken twice");
	halt_wdog_a: assert property (@(posedge REF_CLK) disable iff (RST)
		(DEC_VALID && DEC.halt) |-> (DEC.wdog_clr && DEC.upd_tp))
		else $error("halt without watchdog clear");
	sub_flags_a: assert property (@(posedge REF_CLK) disable iff (RST)
		(DEC_VALID && DEC.unit == IDCT_U_SUB) |-> (DEC.upd_z && DEC.upd_c && DEC.upd_dc))
		else $error("subtract flags wrong");
	dec_flags_a: assert property (@(posedge REF_CLK) disable iff (RST)
		(DEC_VALID && DEC.unit == IDCT_U_DEC) |-> (DEC.upd_z && !DEC.upd_c && !DEC.upd_dc))
		else $error("count down flags wrong");
	timer_long_a: assert property (@(posedge REF_CLK) disable iff (RST)
		(TIMER_TICK && cycle_length_sel_q && $stable(cycle_length_sel_q)) |=> !TIMER_TICK [*3])
		else $error("timer tick faster than a quarter of the oscillator");
	issue_refused_a: assert property (@(posedge REF_CLK) disable iff (RST)
		(state_q != IDCT_S_IDLE) |=> !DEC_VALID)
		else $error("word issued while an instruction runs");
	cycles_range_a: assert property (@(posedge REF_CLK) disable iff (RST)
		DEC_VALID |=> (CYCLES_USED == 2'h1 || CYCLES_USED == 2'h2))
		else $error("cycle count outside one or two");
	pop_only_a: assert property (@(posedge REF_CLK) disable iff (RST)
		(DEC_VALID && DEC.pop_pc) |-> (DEC.branch && !DEC.irq_off && !DEC.upd_z && !DEC.upd_c && !DEC.upd_dc))
		else $error("pop op touches more than the pc");
	irq_exclusive_a: assert property (@(posedge REF_CLK) disable iff (RST)
		(DEC_VALID && DEC.irq_on) |-> !DEC.irq_off)
		else $error("irq enable set and cleared together");
	ctrl_noflag_a: assert property (@(posedge REF_CLK) disable iff (RST)
		(DEC_VALID && (DEC.ctrl_wr || DEC.ctrl_rd)) |-> !(DEC.upd_z || DEC.upd_c || DEC.upd_dc))
		else $error("control copy touches a flag");
	mode_noflag_a: assert property (@(posedge REF_CLK) disable iff (RST)
		(DEC_VALID && (DEC.mode_st || DEC.mode_ld)) |-> !(DEC.upd_z || DEC.upd_c || DEC.upd_dc))
		else $error("mode word copy touches a flag");
	bcd_carry_a: assert property (@(posedge REF_CLK) disable iff (RST)
		(DEC_VALID && DEC.bcd_fix) |-> (DEC.upd_c && !DEC.upd_z && !DEC.upd_dc))
		else $error("bcd fix-up flags wrong");
	clear_zero_a: assert property (@(posedge REF_CLK) disable iff (RST)
		(DEC_VALID && (DEC.zero_acc || (DEC.unit == IDCT_U_CLR && DEC.to_reg))) |-> DEC.upd_z)
		else $error("clear without zero flag update");
	copy_noflag_a: assert property (@(posedge REF_CLK) disable iff (RST)
		(DEC_VALID && DEC.unit == IDCT_U_COPY) |-> !(DEC.upd_z || DEC.upd_c || DEC.upd_dc))
		else $error("accumulator copy touches a flag");
	short_literal_a: assert property (@(posedge REF_CLK) disable iff (RST)
		(DEC_VALID && DEC.unit == IDCT_U_LIT) |-> (!DEC.lit_wide && DEC.literal[9:8] == 2'h0))
		else $error("short literal wider than eight bits");
	bit_field_a: assert property (@(posedge REF_CLK) disable iff (RST)
		(DEC_VALID && (DEC.unit == IDCT_U_BSET || DEC.unit == IDCT_U_BCLR)) |-> DEC.to_reg)
		else $error("bit set or clear not aimed at register");

endmodule

/* File: hw/idct_pkg.sv */
// constants and carrier types for the instruction decode and cycle timing block
// assumes one 25 MHz reference clock and a program memory delivering 13-bit words
package idct_pkg;

	localparam int IDCT_IW        = 13;
	localparam int IDCT_RW        = 6;
	localparam int IDCT_BW        = 3;
	localparam int IDCT_LW        = 10;
	localparam int IDCT_OPT_CLK   = 10;
	localparam int IDCT_PC_REG    = 2;
	localparam int IDCT_PER_SHORT = 2;
	localparam int IDCT_PER_LONG  = 4;
	localparam logic [12:0] IDCT_NOP   = 13'h0000;
	localparam logic [12:0] IDCT_BCD   = 13'h0001;
	localparam logic [12:0] IDCT_MWST  = 13'h0002;
	localparam logic [12:0] IDCT_HALT  = 13'h0003;
	localparam logic [12:0] IDCT_WDCL  = 13'h0004;
	localparam logic [12:0] IDCT_IRQON = 13'h0010;
	localparam logic [12:0] IDCT_IRQOF = 13'h0011;
	localparam logic [12:0] IDCT_POP   = 13'h0012;
	localparam logic [12:0] IDCT_POPI  = 13'h0013;
	localparam logic [12:0] IDCT_MWLD  = 13'h0014;
	localparam logic [12:0] IDCT_ZACC  = 13'h0080;

	typedef enum logic [4:0] {
		IDCT_U_NONE  = 5'h00,
		IDCT_U_COPY  = 5'h01,
		IDCT_U_CLR   = 5'h02,
		IDCT_U_SUB   = 5'h03,
		IDCT_U_DEC   = 5'h04,
		IDCT_U_LOGIC = 5'h05,
		IDCT_U_ADD   = 5'h06,
		IDCT_U_MOVE  = 5'h07,
		IDCT_U_COM   = 5'h08,
		IDCT_U_INC   = 5'h09,
		IDCT_U_DSKIP = 5'h0a,
		IDCT_U_ROT   = 5'h0b,
		IDCT_U_SWAP  = 5'h0c,
		IDCT_U_ISKIP = 5'h0d,
		IDCT_U_BCLR  = 5'h0e,
		IDCT_U_BSET  = 5'h0f,
		IDCT_U_BTSTC = 5'h10,
		IDCT_U_BTSTS = 5'h11,
		IDCT_U_CALL  = 5'h12,
		IDCT_U_JUMP  = 5'h13,
		IDCT_U_LIT   = 5'h14,
		IDCT_U_SYS   = 5'h15
	} idct_unit_type;

	typedef struct packed {
		idct_unit_type        unit;
		logic [1:0]           sub;
		logic [IDCT_RW-1:0]   reg_sel;
		logic [IDCT_BW-1:0]   bit_sel;
		logic [IDCT_LW-1:0]   literal;
		logic                 lit_wide;
		logic                 to_reg;
		logic                 halt;
		logic                 wdog_clr;
		logic                 irq_on;
		logic                 irq_off;
		logic                 pop_pc;
		logic                 ctrl_wr;
		logic                 ctrl_rd;
		logic                 mode_st;
		logic                 mode_ld;
		logic                 bcd_fix;
		logic                 zero_acc;
		logic                 upd_z;
		logic                 upd_c;
		logic                 upd_dc;
		logic                 upd_tp;
		logic                 pc_write;
		logic                 branch;
		logic                 cond_skip;
	} idct_dec_type;

endpackage

/* File: tb/idct_core_tb_top.sv */
// self-checking bench for the decode and cycle timing block
// assumes the program memory model of this folder and static option inputs
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin failures++; \
	$display("[ERR] t=%0t got %h exp %h", $time, (a), (b)); end end
module idct_core_tb_top import idct_pkg::*;;
	logic          REF_CLK = 1'b0;
	logic          RST = 1'b1;
	logic [12:0]   opt = 13'h0000;
	logic          lb = 1'b0;
	logic          load = 1'b0;
	logic [12:0]   nxt_word = 13'h0000;
	logic          nxt_skip = 1'b0;
	logic [12:0]   iword;
	logic          ivalid;
	logic          skip;
	idct_dec_type  dec;
	logic          dec_valid;
	logic          itake;
	logic          cyc_tick;
	logic          tmr_tick;
	logic [1:0]    used;
	int            failures = 0;
	int            tests_run = 0;
	time           last_take = 0;
	time           prev_take = 0;

	always #20 REF_CLK = ~REF_CLK;

	idct_pmem pm (.REF_CLK(REF_CLK), .RST(RST), .LOAD(load), .NEXT_WORD(nxt_word), .NEXT_SKIP(nxt_skip),
		.ITAKE(itake), .IWORD(iword), .IVALID(ivalid), .SKIP_TRUE(skip));
	idct_core dut (.REF_CLK(REF_CLK), .RST(RST), .OPTION_WORD(opt), .LONG_BRANCH_SEL(lb), .IWORD(iword),
		.IVALID(ivalid), .SKIP_TRUE(skip), .DEC(dec), .DEC_VALID(dec_valid), .ITAKE(itake),
		.CYCLE_TICK(cyc_tick), .TIMER_TICK(tmr_tick), .CYCLES_USED(used));

	// --------------------------------
	// shared tasks
	// --------------------------------
	// options only change under reset; other option bits are set to catch wrong bit use
	task automatic opts(input logic c, input logic l);
		@(posedge REF_CLK);
		RST <= 1'b1;
		opt <= {2'b11, c, 10'h3ff};
		lb  <= l;
		repeat (5) @(posedge REF_CLK);
		RST <= 1'b0;
		repeat (2) @(posedge REF_CLK);
	endtask

	task automatic run(input logic [12:0] w, input logic sk);
		int n;
		n = 0;
		@(posedge REF_CLK);
		nxt_word <= w;
		nxt_skip <= sk;
		load     <= 1'b1;
		@(posedge REF_CLK);
		load <= 1'b0;
		do begin
			@(negedge REF_CLK);
			n++;
		end while (dec_valid !== 1'b1 && n < 60);
		`CHK(dec_valid, 1'b1)
		`CHK(itake, 1'b1)
		prev_take = last_take;
		last_take = $time;
		@(negedge REF_CLK);
	endtask

	task automatic gap_chk(input int per);
		int n;
		n = 0;
		@(negedge REF_CLK);
		while (cyc_tick !== 1'b1 && n < 20) begin
			@(negedge REF_CLK);
			n++;
		end
		`CHK(tmr_tick, cyc_tick)
		n = 0;
		do begin
			@(negedge REF_CLK);
			n++;
		end while (cyc_tick !== 1'b1 && n < 20);
		`CHK(n, per)
	endtask

	// --------------------------------
	// scenarios
	// --------------------------------
	task automatic t_fields();
		opts(1'b0, 1'b0);
		run(13'h0b45, 1'b0);
		`CHK(dec.unit, IDCT_U_BSET)
		`CHK(dec.bit_sel, 3'h5)
		`CHK(dec.reg_sel, 6'h05)
		`CHK(used, 2'h1)
		run(13'h1555, 1'b0);
		`CHK({dec.lit_wide, dec.literal}, 11'h555)
		run(13'h18a5, 1'b0);
		`CHK({dec.lit_wide, dec.literal[7:0]}, 9'h0a5)
		run(13'h0e46, 1'b1);
		`CHK({dec.unit, dec.reg_sel}, {IDCT_U_BTSTS, 6'h06})
	endtask

	// flag vector: halt wdog tp irqon irqoff pop cwr crd mst mld bcd zacc z c dc
	localparam logic [12:0] SW [16] = '{13'h0003, 13'h0004, 13'h0010, 13'h0011, 13'h0012, 13'h0013,
		13'h0006, 13'h0016, 13'h0002, 13'h0014, 13'h0001, 13'h0080, 13'h00c6, 13'h0105, 13'h01c5, 13'h0045};
	localparam logic [14:0] SV [16] = '{15'h7000, 15'h3000, 15'h0800, 15'h0400, 15'h0200, 15'h0a00,
		15'h0100, 15'h0080, 15'h0040, 15'h0020, 15'h0012, 15'h000c, 15'h0004, 15'h0007, 15'h0004, 15'h0000};

	task automatic t_sys();
		opts(1'b0, 1'b0);
		for (int i = 0; i < 16; i++) begin
			run(SW[i], 1'b0);
			`CHK({dec.halt, dec.wdog_clr, dec.upd_tp, dec.irq_on, dec.irq_off, dec.pop_pc, dec.ctrl_wr,
				dec.ctrl_rd, dec.mode_st, dec.mode_ld, dec.bcd_fix, dec.zero_acc, dec.upd_z, dec.upd_c,
				dec.upd_dc}, SV[i])
		end
	endtask

	// back-to-back issue of branches, skips and program counter writes in all option pairs
	localparam logic [12:0] BW [6] = '{13'h1555, 13'h0012, 13'h0e45, 13'h0e45, 13'h0042, 13'h03c2};
	localparam logic [5:0]  BS = 6'b000100;

	task automatic t_branch();
		int per;
		int need;
		int prev_need;
		for (int m = 0; m < 4; m++) begin
			opts(m[0], m[1]);
			per = m[0] ? IDCT_PER_LONG : IDCT_PER_SHORT;
			gap_chk(per);
			for (int i = 0; i < 6; i++) begin
				run(BW[i], BS[i]);
				need = (i >= 4) ? 2 : ((i == 3) ? 1 : (m[1] ? 2 : 1));
				`CHK(used, 2'(need))
				if (i > 0) begin
					`CHK((last_take - prev_take) >= 40 * per * prev_need, 1'b1)
				end
				prev_need = need;
			end
		end
	endtask

	// --------------------------------
	// verdict
	// --------------------------------
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// whole run is a few hundred cycles; ten thousand leaves wide margin
	initial begin
		#400000;
		failures++;
		wrap_up();
	end

	initial begin
		repeat (5) @(posedge REF_CLK);
		RST <= 1'b0;
		t_fields();
		t_sys();
		t_branch();
		wrap_up();
	end
endmodule

/* File: tb/idct_pmem.sv */
// program memory model feeding instruction words to the decoder
// assumes the bench pulses LOAD only while no word is outstanding
`timescale 1ns/1ps
module idct_pmem import idct_pkg::*; (
	input  wire logic              REF_CLK,
	input  wire logic              RST,
	input  wire logic              LOAD,
	input  wire logic [IDCT_IW-1:0] NEXT_WORD,
	input  wire logic              NEXT_SKIP,
	input  wire logic              ITAKE,
	output logic [IDCT_IW-1:0]     IWORD,
	output logic                   IVALID,
	output logic                   SKIP_TRUE
);
	// --------------------------------
	// word hand-over
	// --------------------------------
	// a consumed word is inverted so a stale value can never pass for the next one
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			IVALID    <= 1'b0;
			IWORD     <= 13'h1fff;
			SKIP_TRUE <= 1'b0;
		end else if (LOAD) begin
			IVALID    <= 1'b1;
			IWORD     <= NEXT_WORD;
			SKIP_TRUE <= NEXT_SKIP;
		end else if (ITAKE && IVALID) begin
			IVALID    <= 1'b0;
			IWORD     <= ~IWORD;
			SKIP_TRUE <= ~SKIP_TRUE;
		end
	end
endmodule
